// *** pkg/phase_shed_pkg.sv ***
// constants, field layouts and state codes for the phase shedding and nvm lock registers
package phase_shed_pkg;

  // ==========================================================================
  // command codes of the registers held here
  localparam logic [7:0] CMD_PHASE_SHED_CONFIG      = 8'hdf;
  localparam logic [7:0] CMD_MAX_PHASE_LIMIT        = 8'he4;
  localparam logic [7:0] CMD_INPUT_POWER_WARN_LIMIT = 8'hf0;
  localparam logic [7:0] CMD_NVM_PASSWORD           = 8'hfa;

  // page values that select a channel
  localparam logic [7:0] PAGE_CHANNEL_A = 8'h00;
  localparam logic [7:0] PAGE_CHANNEL_B = 8'h01;

  // ==========================================================================
  // phase_shed_config field positions
  localparam int unsigned LIGHT_LOAD_SINGLE_PHASE_MODE_BIT = 15;
  localparam int unsigned TWO_TO_ONE_DROP_OFFSET_LSB       = 13;
  localparam int unsigned FIVE_TO_SIX_ADD_OFFSET_LSB       = 11;
  localparam int unsigned FOUR_TO_FIVE_ADD_OFFSET_LSB      = 9;
  localparam int unsigned THREE_TO_FOUR_ADD_OFFSET_LSB     = 7;
  localparam int unsigned TWO_TO_THREE_ADD_OFFSET_LSB      = 5;
  localparam int unsigned ONE_TO_TWO_ADD_OFFSET_LSB        = 4;
  localparam int unsigned SINGLE_PHASE_SHED_ENABLE_BIT     = 3;
  localparam int unsigned COARSE_THRESHOLD_LSB             = 0;
  // bits 12:7 exist only in the channel a page
  localparam logic [15:0] CHANNEL_A_ONLY_MASK = 16'h1f80;

  // ==========================================================================
  // threshold arithmetic, all in amperes
  localparam logic [7:0] PEAK_EFFICIENCY_BASE = 8'h0c;  // 12 a at code 00b
  localparam logic [7:0] DROP_OFFSET_BASE     = 8'h02;  // code 00b is minus 2 a
  localparam logic [7:0] ADD_OFFSET_BASE      = 8'h06;  // code 00b is plus 6 a
  localparam int unsigned MAX_ADD_STEPS       = 5;

  // ==========================================================================
  // max_phase_limit and input_power_warn_limit layouts
  localparam int unsigned PHASE_NUM_WIDTH          = 3;
  localparam logic [7:0]  PHASE_LIMIT_POWERUP_READ = 8'h00;
  localparam logic [7:0]  OVERPOWER_WARN_RESET     = 8'he1;  // 2 w per lsb

  // ==========================================================================
  // nvm password values and status codes
  localparam logic [15:0] PASSWORD_CLEAR      = 16'hffff;
  localparam logic [15:0] SECURITY_STS_OPEN   = 16'h0000;
  localparam logic [15:0] SECURITY_STS_ARMED  = 16'h0001;
  localparam logic [15:0] SECURITY_STS_LOCKED = 16'h0002;

  // security state, one-hot
  typedef enum logic [3:0] {
    SEC_LOAD   = 4'b0001,
    SEC_OPEN   = 4'b0010,
    SEC_ARMED  = 4'b0100,
    SEC_LOCKED = 4'b1000
  } sec_state_type;

endpackage

// *** rtl/shed_threshold_calc.sv ***
// add and drop current thresholds of one channel from its shedding configuration
`timescale 1ns/1ps
`default_nettype none

module shed_threshold_calc (
  // configuration words
  input  wire logic [15:0] cfg_word,
  input  wire logic [15:0] upper_word,
  // thresholds in amperes
  output logic      [7:0]  drop_thr,
  output logic      [39:0] add_thr
);
  import phase_shed_pkg::*;

  logic [1:0] coarse_code;
  logic [7:0] ieff;
  logic [1:0] drop_code;
  logic [1:0] add_code [1:5];

  // codes above 11b are undefined; clamping them to the top setting keeps thresholds sane
  assign coarse_code = cfg_word[COARSE_THRESHOLD_LSB + 2] ? 2'h3
                     : cfg_word[COARSE_THRESHOLD_LSB +: 2];
  assign ieff        = PEAK_EFFICIENCY_BASE + {5'h00, coarse_code, 1'b0};

  // drop from two phases to one at ieff - 2, +0, +2 or +4 a
  assign drop_code = cfg_word[TWO_TO_ONE_DROP_OFFSET_LSB +: 2];
  assign drop_thr  = ieff + {5'h00, drop_code, 1'b0} - DROP_OFFSET_BASE;

  // the two lower add fields share bit 5, as laid out in the register
  assign add_code[1] = cfg_word[ONE_TO_TWO_ADD_OFFSET_LSB +: 2];
  assign add_code[2] = cfg_word[TWO_TO_THREE_ADD_OFFSET_LSB +: 2];
  assign add_code[3] = upper_word[THREE_TO_FOUR_ADD_OFFSET_LSB +: 2];
  assign add_code[4] = upper_word[FOUR_TO_FIVE_ADD_OFFSET_LSB +: 2];
  assign add_code[5] = upper_word[FIVE_TO_SIX_ADD_OFFSET_LSB +: 2];

  // add a phase at k * ieff + 6, 8, 10 or 12 a
  genvar k;
  for (k = 1; k <= MAX_ADD_STEPS; k++) begin : g_add
    assign add_thr[8*k-1 -: 8] = 8'(k * ieff) + ADD_OFFSET_BASE
                               + {5'h00, add_code[k], 1'b0};
  end

endmodule

`default_nettype wire

// *** rtl/phase_shed_and_nvm_lock_regs.sv ***
// phase shedding configuration, phase limit, overpower limit and nvm password registers
`timescale 1ns/1ps
`default_nettype none

// How it works
// - bit 15 set allows discontinuous conduction on one phase after shedding.
// - two-to-one drop at peak current minus 2, plus 0, 2 or 4 a.
// - step k to k+1 adds at k times peak current plus 6..12 a.
// - upper three add fields live only in page a; rest per channel.
// - shedding to one phase only when bit 3 is set.
// - coarse field picks peak-efficiency current 12, 14, 16 or 18 a.
// - page 00h reaches channel a, page 01h reaches channel b.
// - phase limit code 0..5 caps phases one to six; upper bits zero.
// - programmed limit never raises the hardware phase maximum.
// - phase limit reads zero until either channel first enables.
// - after enable, phase limit reads lower of hardware and programmed.
// - programmed limit above hardware sets warning and raises alert.
// - power limit and password shared, independent of page.
// - overpower limit in bits 7:0, 2 w lsb, resets e1h, upper zero.
// - open state: password write sets key; non-ffffh arms security.
// - armed security rejects writes except page and phase selection and password attempts.
// - wrong password locks; every password refused until power cycle.
// - correct password temporarily opens security for writes again.
// - password read returns 0000h, 0001h or 0002h status.
module phase_shed_and_nvm_lock_regs (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // decoded command port
  input  wire logic                cmd_valid,
  input  wire logic                cmd_write,
  input  wire logic [7:0]          cmd_code,
  input  wire logic [15:0]         cmd_wdata,
  input  wire logic [7:0]          page_sel,
  output logic                     cmd_ready,
  output logic                     resp_valid,
  output logic                     resp_ok,
  output logic [15:0]              resp_rdata,
  // stored defaults
  input  wire logic                nvm_valid,
  input  wire logic [15:0]         nvm_shed_cfg_a,
  input  wire logic [15:0]         nvm_shed_cfg_b,
  input  wire logic [15:0]         nvm_password_key,
  // hardware configuration and converter state
  input  wire logic [2:0]          hw_max_phase_a,
  input  wire logic [2:0]          hw_max_phase_b,
  input  wire logic                conv_enable_a,
  input  wire logic                conv_enable_b,
  // status
  input  wire logic                warn_clear,
  output logic                     maximum_phase_warning,
  output logic                     alert_output,
  output logic                     write_protect,
  // channel a controls
  output logic [2:0]               phase_cap_a,
  output logic                     dcm_enable_a,
  output logic                     shed_one_enable_a,
  output logic [7:0]               drop_thr_a,
  output logic [39:0]              add_thr_a,
  // channel b controls
  output logic [2:0]               phase_cap_b,
  output logic                     dcm_enable_b,
  output logic                     shed_one_enable_b,
  output logic [7:0]               drop_thr_b,
  output logic [39:0]              add_thr_b,
  // shared limit
  output logic [7:0]               overpower_warn_value
);
  import phase_shed_pkg::*;

  // ==========================================================================
  // state
  sec_state_type sec_r;
  sec_state_type sec_nxt;
  logic [15:0]   cfg_a_r;
  logic [15:0]   cfg_b_r;
  logic [2:0]    limit_a_r;
  logic [2:0]    limit_b_r;
  logic [7:0]    opw_r;
  logic [15:0]   key_r;
  logic          seen_enable_r;
  logic          warn_r;
  logic          ready_r;
  logic          resp_valid_r;
  logic          resp_ok_r;
  logic [15:0]   resp_rdata_r;
  logic          protect_r;
  logic [2:0]    cap_a_r;
  logic [2:0]    cap_b_r;
  logic          dcm_a_r;
  logic          dcm_b_r;
  logic          one_a_r;
  logic          one_b_r;
  logic [7:0]    drop_a_r;
  logic [7:0]    drop_b_r;
  logic [39:0]   add_a_r;
  logic [39:0]   add_b_r;

  // ==========================================================================
  // request decode
  logic take;
  logic is_wr;
  logic is_rd;
  logic page_a;
  logic page_b;
  logic page_ok;
  logic hit_cfg;
  logic hit_lim;
  logic hit_opw;
  logic hit_key;
  logic mapped;
  logic cfg_open;

  assign take    = cmd_valid && ready_r;
  assign is_wr   = take && cmd_write;
  assign is_rd   = take && !cmd_write;
  assign page_a  = (page_sel == PAGE_CHANNEL_A);
  assign page_b  = (page_sel == PAGE_CHANNEL_B);
  assign page_ok = page_a || page_b;
  assign hit_cfg = (cmd_code == CMD_PHASE_SHED_CONFIG);
  assign hit_lim = (cmd_code == CMD_MAX_PHASE_LIMIT);
  assign hit_opw = (cmd_code == CMD_INPUT_POWER_WARN_LIMIT);
  assign hit_key = (cmd_code == CMD_NVM_PASSWORD);
  assign mapped  = hit_cfg || hit_lim || hit_opw || hit_key;
  // configuration writes go through only while security is open
  assign cfg_open = (sec_r == SEC_OPEN);

  // ==========================================================================
  // per-register write enables
  logic wr_cfg_a;
  logic wr_cfg_b;
  logic wr_lim_a;
  logic wr_lim_b;
  logic wr_opw;
  logic wr_key;
  logic wr_ok;

  assign wr_cfg_a = is_wr && hit_cfg && page_a && cfg_open;
  assign wr_cfg_b = is_wr && hit_cfg && page_b && cfg_open;
  assign wr_lim_a = is_wr && hit_lim && page_a && cfg_open;
  assign wr_lim_b = is_wr && hit_lim && page_b && cfg_open;
  // shared registers ignore the page entirely
  assign wr_opw   = is_wr && hit_opw && cfg_open;
  // a password attempt is taken in open or armed, never in locked
  assign wr_key   = is_wr && hit_key && (sec_r == SEC_OPEN || sec_r == SEC_ARMED);
  assign wr_ok    = wr_cfg_a || wr_cfg_b || wr_lim_a || wr_lim_b || wr_opw || wr_key;

  // ==========================================================================
  // phase limit: never above the hardware maximum
  logic [2:0] eff_a;
  logic [2:0] eff_b;
  logic [2:0] hw_sel;
  logic       over_hw;

  assign eff_a   = (limit_a_r < hw_max_phase_a) ? limit_a_r : hw_max_phase_a;
  assign eff_b   = (limit_b_r < hw_max_phase_b) ? limit_b_r : hw_max_phase_b;
  assign hw_sel  = page_b ? hw_max_phase_b : hw_max_phase_a;
  // codes 110b and 111b are beyond any hardware maximum and warn too
  assign over_hw = (wr_lim_a || wr_lim_b)
                && (cmd_wdata[PHASE_NUM_WIDTH-1:0] > hw_sel);

  // ==========================================================================
  // read data selection
  logic [15:0] cfg_rd;
  logic [2:0]  lim_rd;
  logic [15:0] key_rd;
  logic [15:0] rd_data;
  logic        rd_ok;

  // channel b shows zero where the page-a-only fields sit
  assign cfg_rd = page_b ? (cfg_b_r & ~CHANNEL_A_ONLY_MASK) : cfg_a_r;
  // zero before either channel has ever run, the lower value after
  assign lim_rd = !seen_enable_r ? PHASE_LIMIT_POWERUP_READ[2:0]
                : (page_b ? eff_b : eff_a);
  // the key itself is never returned, only the security status
  assign key_rd = (sec_r == SEC_LOCKED) ? SECURITY_STS_LOCKED
                : (sec_r == SEC_ARMED)  ? SECURITY_STS_ARMED
                :                         SECURITY_STS_OPEN;
  assign rd_data = hit_cfg ? cfg_rd
                 : hit_lim ? {13'h0000, lim_rd}
                 : hit_opw ? {8'h00, opw_r}
                 : hit_key ? key_rd
                 :           16'h0000;
  // paged registers refuse a page that names no channel
  assign rd_ok = mapped && ((hit_cfg || hit_lim) ? page_ok : 1'b1);

  // ==========================================================================
  // security state machine
  always_comb begin
    sec_nxt = sec_r;
    case (sec_r)
      SEC_LOAD: begin
        if (nvm_valid) begin
          sec_nxt = (nvm_password_key == PASSWORD_CLEAR) ? SEC_OPEN : SEC_ARMED;
        end
      end
      SEC_OPEN: begin
        if (wr_key && cmd_wdata != PASSWORD_CLEAR) begin
          sec_nxt = SEC_ARMED;
        end
      end
      SEC_ARMED: begin
        if (wr_key) begin
          sec_nxt = (cmd_wdata == key_r) ? SEC_OPEN : SEC_LOCKED;
        end
      end
      SEC_LOCKED: begin
        sec_nxt = SEC_LOCKED;  // only a reset leaves this state
      end
      default: begin
        sec_nxt = SEC_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sec_r <= SEC_LOAD;
    end else begin
      sec_r <= sec_nxt;
    end
  end

  // password key; loaded from nvm, replaced only while open
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      key_r <= PASSWORD_CLEAR;
    end else if (sec_r == SEC_LOAD && nvm_valid) begin
      key_r <= nvm_password_key;
    end else if (wr_key && sec_r == SEC_OPEN) begin
      key_r <= cmd_wdata;
    end
  end

  // ==========================================================================
  // shedding configuration per channel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_a_r <= 16'h0000;
      cfg_b_r <= 16'h0000;
    end else if (sec_r == SEC_LOAD && nvm_valid) begin
      cfg_a_r <= nvm_shed_cfg_a;
      cfg_b_r <= nvm_shed_cfg_b & ~CHANNEL_A_ONLY_MASK;
    end else begin
      if (wr_cfg_a) begin
        cfg_a_r <= cmd_wdata;
      end
      if (wr_cfg_b) begin
        cfg_b_r <= cmd_wdata & ~CHANNEL_A_ONLY_MASK;
      end
    end
  end

  // programmed phase limits; power-up value is the widest code
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      limit_a_r <= 3'h7;
      limit_b_r <= 3'h7;
    end else begin
      if (wr_lim_a) begin
        limit_a_r <= cmd_wdata[PHASE_NUM_WIDTH-1:0];
      end
      if (wr_lim_b) begin
        limit_b_r <= cmd_wdata[PHASE_NUM_WIDTH-1:0];
      end
    end
  end

  // shared overpower warning limit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opw_r <= OVERPOWER_WARN_RESET;
    end else if (wr_opw) begin
      opw_r <= cmd_wdata[7:0];
    end
  end

  // sticky record that conversion has ever been enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seen_enable_r <= 1'b0;
    end else if (conv_enable_a || conv_enable_b) begin
      seen_enable_r <= 1'b1;
    end
  end

  // warning flag: a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      warn_r <= 1'b0;
    end else if (over_hw) begin
      warn_r <= 1'b1;
    end else if (warn_clear) begin
      warn_r <= 1'b0;
    end
  end

  // ==========================================================================
  // command port: ready after the nvm load, one answer per request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready_r      <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_ok_r    <= 1'b0;
      resp_rdata_r <= 16'h0000;
    end else begin
      ready_r      <= (sec_nxt != SEC_LOAD);  // no access before defaults land
      resp_valid_r <= take;
      resp_ok_r    <= take && (cmd_write ? wr_ok : rd_ok);  // refused writes answer low
      resp_rdata_r <= (is_rd && rd_ok) ? rd_data : 16'h0000;
    end
  end

  // ==========================================================================
  // threshold arithmetic; channel b reuses the page-a-only add fields
  logic [7:0]  drop_a_w;
  logic [7:0]  drop_b_w;
  logic [39:0] add_a_w;
  logic [39:0] add_b_w;

  shed_threshold_calc u_thr_a (
    .cfg_word   (cfg_a_r),
    .upper_word (cfg_a_r),
    .drop_thr   (drop_a_w),
    .add_thr    (add_a_w)
  );

  shed_threshold_calc u_thr_b (
    .cfg_word   (cfg_b_r),
    .upper_word (cfg_a_r),
    .drop_thr   (drop_b_w),
    .add_thr    (add_b_w)
  );

  // registered controls toward the phase logic
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      protect_r <= 1'b1;
      cap_a_r   <= 3'h0;
      cap_b_r   <= 3'h0;
      dcm_a_r   <= 1'b0;
      dcm_b_r   <= 1'b0;
      one_a_r   <= 1'b0;
      one_b_r   <= 1'b0;
      drop_a_r  <= 8'h00;
      drop_b_r  <= 8'h00;
      add_a_r   <= 40'h00_0000_0000;
      add_b_r   <= 40'h00_0000_0000;
    end else begin
      protect_r <= (sec_nxt != SEC_OPEN);  // other commands bar writes but page/phase
      cap_a_r   <= eff_a;
      cap_b_r   <= eff_b;
      dcm_a_r   <= cfg_a_r[LIGHT_LOAD_SINGLE_PHASE_MODE_BIT];
      dcm_b_r   <= cfg_b_r[LIGHT_LOAD_SINGLE_PHASE_MODE_BIT];
      one_a_r   <= cfg_a_r[SINGLE_PHASE_SHED_ENABLE_BIT];
      one_b_r   <= cfg_b_r[SINGLE_PHASE_SHED_ENABLE_BIT];
      drop_a_r  <= drop_a_w;
      drop_b_r  <= drop_b_w;
      add_a_r   <= add_a_w;
      add_b_r   <= add_b_w;
    end
  end

  // ==========================================================================
  // outputs straight from flip-flops
  assign cmd_ready             = ready_r;
  assign resp_valid            = resp_valid_r;
  assign resp_ok               = resp_ok_r;
  assign resp_rdata            = resp_rdata_r;
  assign maximum_phase_warning = warn_r;
  assign alert_output          = warn_r;
  assign write_protect         = protect_r;
  assign phase_cap_a           = cap_a_r;
  assign phase_cap_b           = cap_b_r;
  assign dcm_enable_a          = dcm_a_r;
  assign dcm_enable_b          = dcm_b_r;
  assign shed_one_enable_a     = one_a_r;
  assign shed_one_enable_b     = one_b_r;
  assign drop_thr_a            = drop_a_r;
  assign drop_thr_b            = drop_b_r;
  assign add_thr_a             = add_a_r;
  assign add_thr_b             = add_b_r;
  assign overpower_warn_value  = opw_r;

endmodule

`default_nettype wire

// *** dv/phase_shed_regs_chk.sv ***
// checker of answers, limits and status of the shed and lock registers
`timescale 1ns/1ps
`default_nettype none
module phase_shed_regs_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // command port
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_ready,
  input wire logic        resp_valid,
  input wire logic        resp_ok,
  input wire logic [15:0] resp_rdata,
  // status and caps
  input wire logic [2:0]  hw_max_phase_a,
  input wire logic        warn_clear,
  input wire logic        maximum_phase_warning,
  input wire logic        alert_output,
  input wire logic        write_protect,
  input wire logic [2:0]  phase_cap_a
);
  // ====================
  // request sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_read(logic [7:0] c);
    s_take ##0 (!cmd_write && cmd_code == c);
  endsequence
  // ====================
  // answers, then status
  a_resp_after_take: assert property (s_take |=> resp_valid)
    else $error("request taken without an answer");
  a_resp_only_taken: assert property (!(cmd_valid && cmd_ready) |=> !resp_valid)
    else $error("answer without a request");
  a_ready_holds: assert property (cmd_ready |=> cmd_ready)
    else $error("ready dropped");
  a_limit_upper_zero: assert property (s_read(8'he4) |=> resp_rdata[15:3] == 13'h0)
    else $error("phase limit upper bits set");
  a_power_upper_zero: assert property (s_read(8'hf0) |=> resp_rdata[15:8] == 8'h00)
    else $error("power limit upper byte set");
  a_status_code: assert property (s_read(8'hfa) |=> resp_ok && resp_rdata <= 16'h2)
    else $error("bad password status");
  a_alert_tracks: assert property (alert_output == maximum_phase_warning)
    else $error("alert differs from warning");
  a_warn_sticky: assert property (maximum_phase_warning && !warn_clear
    |=> maximum_phase_warning)
    else $error("warning lost");
  a_cap_bounded: assert property (phase_cap_a <= hw_max_phase_a)
    else $error("cap above hardware maximum");
  // protection on both sides of the request means security was not open
  a_locked_refuse: assert property ((s_take ##0 (cmd_write && cmd_code == 8'hdf && write_protect))
    ##1 write_protect |-> !resp_ok)
    else $error("protected write accepted");
endmodule
bind phase_shed_and_nvm_lock_regs phase_shed_regs_chk u_chk (.*);
`default_nettype wire

// *** dv/host_model.sv ***
// behavioural host placing one command at a time on the request port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and answer
  input  wire logic        clk,
  input  wire logic        cmd_ready,
  input  wire logic        resp_valid,
  input  wire logic        resp_ok,
  input  wire logic [15:0] resp_rdata,
  // request
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  output logic [7:0]       page_sel
);
  // ====================
  // idle lines
  initial begin
    cmd_valid = 1'b0;
    {cmd_write, cmd_code, cmd_wdata, page_sel} = 33'h0;
  end
  // ====================
  // request held until taken or 64 more cycles pass; released lines show the inverse so a stale
  // value can never pass for a live one
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p,
                      input logic [15:0] v, output logic ok, output logic [15:0] rd,
                      output logic hung);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    {cmd_write, cmd_code, cmd_wdata, page_sel} = {w, c, v, p};
    n = 0;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 64) begin
      n++;
      @(posedge clk);
    end
    @(negedge clk);
    hung = resp_valid !== 1'b1;
    ok = resp_ok;
    rd = resp_rdata;
    cmd_valid = 1'b0;
    {cmd_write, cmd_code, cmd_wdata, page_sel} = ~{w, c, v, p};
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the phase shedding and nvm lock registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  // ====================
  // design signals and model state
  logic        clk, reset, cmd_valid, cmd_write, cmd_ready, resp_valid, resp_ok, nvm_valid;
  logic        conv_enable_a, conv_enable_b, warn_clear, maximum_phase_warning, warn;
  logic        alert_output, write_protect, dcm_enable_a, dcm_enable_b;
  logic        shed_one_enable_a, shed_one_enable_b;
  logic [7:0]  cmd_code, page_sel, drop_thr_a, drop_thr_b, overpower_warn_value;
  logic [15:0] cmd_wdata, resp_rdata, nvm_shed_cfg_a, nvm_shed_cfg_b, nvm_password_key;
  logic [2:0]  hw_max_phase_a, hw_max_phase_b, phase_cap_a, phase_cap_b;
  logic [39:0] add_thr_a, add_thr_b;
  logic [15:0] cfg [2], d, pwd;
  logic [7:0]  wc [3] = '{8'hdf, 8'he4, 8'hf0};
  int          lim [2], hw [2] = '{3, 1}, pw, key, sec, ens, i;
  int          bad_count = 0, total_checks = 0;
  wire logic [52:0] out_a = {dcm_enable_a, shed_one_enable_a, phase_cap_a, drop_thr_a, add_thr_a};
  wire logic [52:0] out_b = {dcm_enable_b, shed_one_enable_b, phase_cap_b, drop_thr_b, add_thr_b};
  phase_shed_and_nvm_lock_regs u_phase_shed_and_nvm_lock_regs (.*);
  host_model u_host_model (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====================
  // reference model
  function automatic int cap(int p);
    return lim[p] < hw[p] ? lim[p] : hw[p];
  endfunction
  // channel b borrows the upper add fields of channel a
  function automatic logic [52:0] chan(int p);
    int pk;
    logic [15:0] c;
    c = cfg[p];
    pk = 12 + 2 * (c[2:0] > 3 ? 3 : int'(c[2:0]));
    return {c[15], c[3], 3'(cap(p)), 8'(pk - 2 + 2 * c[14:13]), 8'(5 * pk + 6 + 2 * cfg[0][12:11]),
            8'(4 * pk + 6 + 2 * cfg[0][10:9]), 8'(3 * pk + 6 + 2 * cfg[0][8:7]),
            8'(2 * pk + 6 + 2 * c[6:5]), 8'(pk + 6 + 2 * c[5:4])};
  endfunction
  task do_reset;
    @(negedge clk);
    reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    nvm_valid = 1'b1;
    cfg = '{nvm_shed_cfg_a, nvm_shed_cfg_b & 16'he07f};
    lim = '{7, 7};
    pw = 'he1;
    sec = int'(nvm_password_key != 16'hffff);
    key = nvm_password_key;
    ens = 0;
    warn = 1'b0;
  endtask
  task op(input logic w, input logic [7:0] c, input int p, input logic [15:0] v);
    logic ok, hung, eok;
    logic [15:0] rd, erd;
    // df and e4 are paged, f0 and fa are shared
    eok = (c inside {8'hdf, 8'he4, 8'hf0, 8'hfa}) && (p < 2 || c > 8'he4)
          && (!w || sec == 0 || (c == 8'hfa && sec == 1));
    erd = 16'h0;
    if (eok && !w) begin
      case (c)
        8'hdf: erd = cfg[p];
        8'he4: erd = 16'(ens ? cap(p) : 0);
        8'hf0: erd = 16'(pw);
        default: erd = 16'(sec);
      endcase
    end else if (eok) begin
      case (c)
        8'hdf: cfg[p] = p ? v & 16'he07f : v;
        8'he4: begin
          lim[p] = int'(v[2:0]);
          warn |= lim[p] > hw[p];
        end
        8'hf0: pw = int'(v[7:0]);
        default: begin
          sec = sec ? (v == key ? 0 : 2) : int'(v != 16'hffff);
          if (sec == 1) key = v;
        end
      endcase
    end
    u_host_model.xfer(w, c, 8'(p), v, ok, rd, hung);
    `CHK(hung, 1'b0)
    if (hung) test_done();
    `CHK({ok, rd}, {eok, erd})
  endtask
  task chk_all;
    @(negedge clk);
    `CHK(out_a, chan(0))
    `CHK(out_b, chan(1))
    `CHK(overpower_warn_value, 8'(pw))
    `CHK({alert_output, maximum_phase_warning, write_protect}, {warn, warn, sec != 0})
  endtask
  task try_writes;
    for (int k = 0; k < 3; k++) op(1'b1, wc[k], 0, 16'h0001);
    chk_all();
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ====================
  // scenarios
  initial begin
    void'($urandom(32'h3621));
    {reset, nvm_valid, conv_enable_a, conv_enable_b, warn_clear} = 5'b10000;
    nvm_shed_cfg_a = 16'($urandom);
    nvm_shed_cfg_b = 16'($urandom);
    nvm_password_key = 16'hffff;
    {hw_max_phase_a, hw_max_phase_b} = 6'o31;
    do_reset();
    op(1'b0, 8'he4, 0, 16'h0);
    for (i = 0; i < 2; i++) op(1'b0, 8'hdf, i, 16'h0);
    chk_all();
    $display("test power-up done");
    for (i = 0; i < 8; i++) begin
      d = 16'($urandom);
      d[2:0] = 3'(i);
      d[14:13] = 2'(i);
      op(1'b1, 8'hdf, i % 2, d);
      op(1'b0, 8'hdf, i % 2, 16'h0);
      chk_all();
    end
    op(1'b1, 8'hdf, 2, d);
    op(1'b0, 8'h55, 0, 16'h0);
    $display("test shedding done");
    @(negedge clk) conv_enable_a = 1'b1;
    @(negedge clk) conv_enable_a = 1'b0;
    ens = 1;
    op(1'b0, 8'he4, 0, 16'h0);
    op(1'b1, 8'he4, 0, 16'hfff2);
    op(1'b1, 8'he4, 1, 16'h0005);
    op(1'b0, 8'he4, 1, 16'h0);
    chk_all();
    @(negedge clk) warn_clear = 1'b1;
    @(negedge clk) warn_clear = 1'b0;
    warn = 1'b0;
    op(1'b1, 8'hf0, 1, 16'hab5a);
    op(1'b0, 8'hf0, 0, 16'h0);
    chk_all();
    $display("test limits done");
    pwd = 16'($urandom) & 16'h7fff;
    op(1'b1, 8'hfa, 0, pwd);
    try_writes();
    op(1'b1, 8'hfa, 1, pwd);
    try_writes();
    op(1'b1, 8'hfa, 0, 16'hffff);
    op(1'b1, 8'hfa, 0, pwd);
    op(1'b1, 8'hfa, 1, ~pwd);
    op(1'b1, 8'hfa, 0, pwd);
    try_writes();
    op(1'b0, 8'hfa, 1, 16'h0);
    $display("test security done");
    // a stored enable must come back armed after the power cycle
    nvm_password_key = pwd;
    do_reset();
    op(1'b0, 8'hfa, 0, 16'h0);
    chk_all();
    op(1'b1, 8'hfa, 1, pwd);
    @(negedge clk) conv_enable_b = 1'b1;
    @(negedge clk) conv_enable_b = 1'b0;
    ens = 1;
    op(1'b0, 8'he4, 1, 16'h0);
    op(1'b0, 8'he4, 2, 16'h0);
    chk_all();
    $display("test power cycle done");
    test_done();
  end
endmodule
`default_nettype wire
